/* design/gage_slot_pkg.sv */
`default_nettype none
package gage_slot_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_HZ       = 250000000;
  localparam longint DEB_SHORT_MS = 20;
  localparam longint DEB_LONG_MS  = 100;
  localparam int DEB_SHORT_CYC = int'((DEB_SHORT_MS * CLK_HZ) / 1000);
  localparam int DEB_LONG_CYC  = int'((DEB_LONG_MS * CLK_HZ) / 1000);
  // ----------------------------------------
  // Slot switch bit positions (position 1 is bit 0)
  // ----------------------------------------
  localparam int SW_UNITS  = 0;
  localparam int SW_CHID   = 1;
  localparam int SW_SEL3   = 2;
  localparam int SW_CONT   = 3;
  localparam int SW_FMT_LO = 4;
  localparam int SW_FMT_HI = 6;
  // Format codes as {pos7,pos6,pos5}
  localparam logic [2:0] FMT_CODE_STD   = 3'h0;
  localparam logic [2:0] FMT_CODE_LEFT  = 3'h4;
  localparam logic [2:0] FMT_CODE_RUN   = 3'h1;
  localparam logic [2:0] FMT_CODE_PRN   = 3'h2;
  localparam logic [2:0] FMT_CODE_MUX   = 3'h3;
  // ----------------------------------------
  // Decimal handling
  // ----------------------------------------
  localparam logic [2:0] DEC_MAX   = 3'h7;
  localparam logic [2:0] DEC_THREE = 3'h3;
  localparam logic [2:0] DEC_FOUR  = 3'h4;
  localparam logic [2:0] DEC_FIVE  = 3'h5;
  // Dial cable wiring codes
  localparam logic [1:0] WIRE_D3  = 2'h0;
  localparam logic [1:0] WIRE_D4  = 2'h1;
  localparam logic [1:0] WIRE_D5  = 2'h2;
  localparam logic [1:0] WIRE_SEL = 2'h3;
  // Multiplier decimal shift codes
  localparam logic [1:0] SHIFT_NONE  = 2'h0;
  localparam logic [1:0] SHIFT_LEFT  = 2'h1;
  localparam logic [1:0] SHIFT_RIGHT = 2'h2;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    FAM_STD, FAM_STD_LIKE, FAM_ANGLE, FAM_DIAL,
    FAM_SPRING, FAM_LINEAR, FAM_BTN_ONLY, FAM_CHIP
  } fam_t;
  typedef enum logic [2:0] {
    FMT_STANDARD, FMT_LEFT_JUSTIFY, FMT_RUNOUT, FMT_PRINTER, FMT_LEGACY_MUX
  } fmt_t;
  typedef enum logic [1:0] {
    INIT_PEND, INIT_WAKE, RUN
  } init_st_t;
endpackage
`default_nettype wire

/* design/gage_slot_reader.sv */
// Operation
// - Button-only gages read only from own button
// - Dial decimals from cable wiring and switch
// - Standard-like gage powered on, identified at reset
// - Blank display on gage: no value reported
// - Slow chip gage: no zeroing, remote/host only
// - Fast chip gage: zero at reset, button reads
// - Lost fast mode returns only after reset
// - Multiplier inverts sign, shifts decimal one place
// - Position 1 selects units field
// - Position 2 selects channel id, runout label
// - Chip gages: position 3 inch or mm
// - Selectable dial cable: position 3 three/five
// - Position 4 continuous or single reading
// - Positions 5-7 select output format
// - Standard family: button, remote or host trigger
// - Angle family handled as standard type
// - Dial/spring/linear: remote or host only
// - Standard-like family identified as standard
// - Switch open for debounce before new closure
`default_nettype none
module gage_slot_reader #(
  parameter int N         = 4,                          // Inputs per slot
  parameter int W         = 24,                         // Measurement width
  parameter int DEB_SHORT = gage_slot_pkg::DEB_SHORT_CYC, // Short open time
  parameter int DEB_LONG  = gage_slot_pkg::DEB_LONG_CYC   // Long open time
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          srst_i,
  input  wire logic [7:0]                    slot_sw_i,      // Slot switch bank
  input  wire logic                          deb_short_i,    // Short debounce
  input  wire logic                          mult_invert_i,  // Invert sign
  input  wire logic [1:0]                    mult_shift_i,   // Decimal shift
  input  wire gage_slot_pkg::fam_t [N-1:0]   family_i,       // Attached family
  input  wire logic [N-1:0][1:0]             dec_wiring_i,   // Dial cable
  input  wire logic [N-1:0]                  fast_cable_i,   // Chip fast cable
  input  wire logic [N-1:0]                  gage_btn_i,     // Gage button pulse
  input  wire logic [N-1:0]                  remote_sw_i,    // Switch closed
  input  wire logic [N-1:0]                  host_read_i,    // Host read pulse
  input  wire logic [N-1:0]                  gage_on_i,      // Gage is on
  input  wire logic [N-1:0]                  gage_blank_i,   // Blank display
  input  wire logic [N-1:0]                  fast_lost_i,    // Left fast mode
  input  wire logic [N-1:0]                  frame_valid_i,  // Frame arrived
  input  wire logic [N-1:0][W-1:0]           frame_value_i,  // Signed mantissa
  input  wire logic [N-1:0][2:0]             frame_dec_i,    // Frame decimals
  input  wire logic [N-1:0]                  frame_inch_i,   // Frame in inches
  output logic [N-1:0]                       read_req_o,     // Ask gage
  output logic [N-1:0]                       power_on_o,     // Wake gage
  output logic [N-1:0]                       zero_o,         // Zero gage
  output logic [N-1:0]                       ident_o,        // Gage identified
  output gage_slot_pkg::fam_t [N-1:0]        gage_type_o,    // Identified type
  output logic [N-1:0]                       fast_ok_o,      // Fast mode live
  output logic [N-1:0]                       meas_valid_o,   // Result pulse
  output logic [N-1:0][W-1:0]                meas_value_o,   // Scaled value
  output logic [N-1:0][2:0]                  meas_dec_o,     // Decimals
  output logic [N-1:0]                       meas_inch_o,    // Units inch
  output logic                               send_units_o,
  output logic                               send_chan_id_o,
  output logic                               send_runout_label_o,
  output logic                               continuous_o,
  output gage_slot_pkg::fmt_t                fmt_mode_o
);
  import gage_slot_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (N < 1 || W < 2 || DEB_SHORT < 1 || DEB_SHORT > DEB_LONG) begin : g_bad
    $error("gage_slot_reader: bad parameters");
  end

  localparam int CW = $clog2(DEB_LONG + 1);
  localparam logic [CW-1:0] CNT_SAT   = CW'(DEB_LONG);
  localparam logic [CW-1:0] CNT_SHORT = CW'(DEB_SHORT);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    init_st_t        st;        // Reset sequence
    logic            armed;     // Waiting for frame
    logic            sw_prev;   // Last switch level
    logic [CW-1:0]   open_cnt;  // Time switch open
    logic            fast_ok;   // Fast mode valid
    logic            read_req;
    logic            power_on;
    logic            zero;
    logic            ident;
    fam_t            gtype;
    logic            mvalid;
    logic [W-1:0]    mvalue;
    logic [2:0]      mdec;
    logic            minch;
  } ch_t;

  typedef struct packed {
    ch_t [N-1:0]  ch;
    logic         units;
    logic         chid;
    logic         runlbl;
    logic         cont;
    fmt_t         fmt;
  } state_t;

  // Counter reset saturated so the first closure is taken
  localparam ch_t CH_RST = '{
    st: INIT_PEND, armed: 1'b0, sw_prev: 1'b0, open_cnt: CNT_SAT,
    fast_ok: 1'b0, read_req: 1'b0, power_on: 1'b0, zero: 1'b0,
    ident: 1'b0, gtype: FAM_STD, mvalid: 1'b0, mvalue: '0,
    mdec: '0, minch: 1'b0};

  state_t st_ff;
  state_t nxt_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic       btn_ok;
    logic       rem_ok;
    logic       closed_new;
    logic       trig;
    logic [2:0] base_dec;
    logic [2:0] fmt_code;
    fam_t       fam;
    btn_ok     = 1'b0;
    rem_ok     = 1'b0;
    closed_new = 1'b0;
    trig       = 1'b0;
    base_dec   = '0;
    fmt_code   = '0;
    fam        = FAM_STD;
    nxt_st     = st_ff;

    // Slot-wide switch decode
    nxt_st.units  = slot_sw_i[SW_UNITS];
    nxt_st.chid   = slot_sw_i[SW_CHID];
    nxt_st.cont   = slot_sw_i[SW_CONT];
    fmt_code      = slot_sw_i[SW_FMT_HI:SW_FMT_LO];
    unique case (fmt_code)
      FMT_CODE_STD:  nxt_st.fmt = FMT_STANDARD;
      FMT_CODE_LEFT: nxt_st.fmt = FMT_LEFT_JUSTIFY;
      FMT_CODE_RUN:  nxt_st.fmt = FMT_RUNOUT;
      FMT_CODE_PRN:  nxt_st.fmt = FMT_PRINTER;
      FMT_CODE_MUX:  nxt_st.fmt = FMT_LEGACY_MUX;
      // Undefined codes fall back to standard output
      default:       nxt_st.fmt = FMT_STANDARD;
    endcase
    // Label only goes out with the id in runout format
    nxt_st.runlbl = slot_sw_i[SW_CHID] && (fmt_code == FMT_CODE_RUN);

    // Every input runs on its own slice of state
    for (int i = 0; i < N; i++) begin
      fam = family_i[i];
      // Pulses last one cycle
      nxt_st.ch[i].read_req = 1'b0;
      nxt_st.ch[i].power_on = 1'b0;
      nxt_st.ch[i].zero     = 1'b0;
      nxt_st.ch[i].ident    = 1'b0;
      nxt_st.ch[i].mvalid   = 1'b0;

      // Which trigger sources this family honours
      unique case (fam)
        FAM_STD, FAM_ANGLE: begin
          btn_ok = 1'b1;
          rem_ok = 1'b1;
        end
        FAM_BTN_ONLY: begin
          btn_ok = 1'b1;
          rem_ok = 1'b0;
        end
        FAM_CHIP: begin
          // Zero button reads only while fast mode holds
          btn_ok = st_ff.ch[i].fast_ok;
          rem_ok = 1'b1;
        end
        default: begin
          btn_ok = 1'b0;
          rem_ok = 1'b1;
        end
      endcase

      // Switch debounce: count open time, saturating
      nxt_st.ch[i].sw_prev = remote_sw_i[i];
      if (remote_sw_i[i]) begin
        nxt_st.ch[i].open_cnt = '0;
      end else if (st_ff.ch[i].open_cnt != CNT_SAT) begin
        nxt_st.ch[i].open_cnt = st_ff.ch[i].open_cnt + 1'b1;
      end
      // Closure counts only after a long enough open spell
      closed_new = remote_sw_i[i] && !st_ff.ch[i].sw_prev &&
                   (st_ff.ch[i].open_cnt >= (deb_short_i ? CNT_SHORT : CNT_SAT));

      trig = (btn_ok && gage_btn_i[i]) ||
             (rem_ok && (closed_new || host_read_i[i]));

      // Lost fast mode stays lost until the next reset
      if (fast_lost_i[i]) begin
        nxt_st.ch[i].fast_ok = 1'b0;
      end

      // Decimals: dial strings carry none, take them from wiring
      if (fam == FAM_DIAL) begin
        unique case (dec_wiring_i[i])
          WIRE_D3:  base_dec = DEC_THREE;
          WIRE_D4:  base_dec = DEC_FOUR;
          WIRE_D5:  base_dec = DEC_FIVE;
          WIRE_SEL: base_dec = slot_sw_i[SW_SEL3] ? DEC_THREE : DEC_FIVE;
        endcase
      end else begin
        base_dec = frame_dec_i[i];
      end

      unique case (st_ff.ch[i].st)
        INIT_PEND: begin
          // Standard-like and angle families report as standard
          nxt_st.ch[i].gtype = (fam == FAM_STD_LIKE || fam == FAM_ANGLE) ?
                               FAM_STD : fam;
          if (fam == FAM_STD_LIKE && !gage_on_i[i]) begin
            nxt_st.ch[i].power_on = 1'b1;
            nxt_st.ch[i].st       = INIT_WAKE;
          end else begin
            nxt_st.ch[i].ident = 1'b1;
            nxt_st.ch[i].st    = RUN;
          end
          // Slow cable leaves the gage untouched
          if (fam == FAM_CHIP && fast_cable_i[i]) begin
            nxt_st.ch[i].zero    = 1'b1;
            nxt_st.ch[i].fast_ok = 1'b1;
          end else begin
            nxt_st.ch[i].fast_ok = 1'b0;
          end
        end
        INIT_WAKE: begin
          // Hold until the woken gage reports on
          if (gage_on_i[i]) begin
            nxt_st.ch[i].ident = 1'b1;
            nxt_st.ch[i].st    = RUN;
          end
        end
        RUN: begin
          // Continuous mode keeps a request outstanding
          if (trig || (st_ff.cont && rem_ok && !st_ff.ch[i].armed)) begin
            nxt_st.ch[i].armed    = 1'b1;
            nxt_st.ch[i].read_req = rem_ok;
          end
          // No frame timing assumed: slow and fast rates both fit
          if (frame_valid_i[i] && (st_ff.ch[i].armed || trig)) begin
            nxt_st.ch[i].armed = 1'b0;
            // Blank display consumes the trigger, reports nothing
            if (!gage_blank_i[i]) begin
              nxt_st.ch[i].mvalid = 1'b1;
              nxt_st.ch[i].mvalue = mult_invert_i ?
                                    W'(-frame_value_i[i]) : frame_value_i[i];
              unique case (mult_shift_i)
                SHIFT_LEFT:  nxt_st.ch[i].mdec = (base_dec == DEC_MAX) ?
                                                 DEC_MAX : base_dec + 3'h1;
                SHIFT_RIGHT: nxt_st.ch[i].mdec = (base_dec == 3'h0) ?
                                                 3'h0 : base_dec - 3'h1;
                default:     nxt_st.ch[i].mdec = base_dec;
              endcase
              nxt_st.ch[i].minch = (fam == FAM_CHIP) ?
                                   slot_sw_i[SW_SEL3] : frame_inch_i[i];
            end
          end
        end
        default: nxt_st.ch[i].st = INIT_PEND;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Only a full reset re-runs the wake/zero sequence
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < N; i++) begin
        st_ff.ch[i] <= CH_RST;
      end
      st_ff.units  <= 1'b0;
      st_ff.chid   <= 1'b0;
      st_ff.runlbl <= 1'b0;
      st_ff.cont   <= 1'b0;
      st_ff.fmt    <= FMT_STANDARD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs, straight from flops
  // ----------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_out
    assign read_req_o[i]   = st_ff.ch[i].read_req;
    assign power_on_o[i]   = st_ff.ch[i].power_on;
    assign zero_o[i]       = st_ff.ch[i].zero;
    assign ident_o[i]      = st_ff.ch[i].ident;
    assign gage_type_o[i]  = st_ff.ch[i].gtype;
    assign fast_ok_o[i]    = st_ff.ch[i].fast_ok;
    assign meas_valid_o[i] = st_ff.ch[i].mvalid;
    assign meas_value_o[i] = st_ff.ch[i].mvalue;
    assign meas_dec_o[i]   = st_ff.ch[i].mdec;
    assign meas_inch_o[i]  = st_ff.ch[i].minch;
  end
  assign send_units_o        = st_ff.units;
  assign send_chan_id_o      = st_ff.chid;
  assign send_runout_label_o = st_ff.runlbl;
  assign continuous_o        = st_ff.cont;
  assign fmt_mode_o          = st_ff.fmt;
endmodule // gage_slot_reader
`default_nettype wire

/* verif/gage_model.sv */
`default_nettype none
module gage_model #(
  parameter int         W   = 24,
  parameter logic [W-1:0] VAL = '0 // Reading sent
) (
  input  wire logic         clk_i,
  input  wire logic         req_i,  // Read request
  input  wire logic         btn_i,  // Own button
  input  wire logic         wake_i, // Power-on pulse
  input  wire logic [7:0]   dly_i,  // Answer delay
  output logic              frame_valid_o,
  output logic [W-1:0]      frame_value_o,
  output logic              on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff; // Cycles to frame, 0 idle
  initial begin
    frame_valid_o = 1'b0;
    frame_value_o = '0;
    on_o = 1'b0;
    cnt_ff = 8'h00;
  end
  // Data is not held outside a frame, so it toggles
  always @(posedge clk_i) begin
    frame_valid_o <= 1'b0;
    frame_value_o <= ~frame_value_o;
    if (wake_i) on_o <= 1'b1;
    if (req_i || btn_i) cnt_ff <= dly_i;
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    if (cnt_ff == 8'h01) begin
      frame_valid_o <= 1'b1;
      frame_value_o <= VAL;
    end
  end
endmodule // gage_model
`default_nettype wire

/* verif/gage_slot_asserts.sv */
`default_nettype none
module gage_slot_asserts #(
  parameter int N = 4
) (
  input wire logic                        sys_clk_i,
  input wire logic                        srst_i,
  input wire logic [7:0]                  slot_sw_i,
  input wire gage_slot_pkg::fam_t [N-1:0] family_i,
  input wire logic [N-1:0]                fast_cable_i,
  input wire logic [N-1:0]                host_read_i,
  input wire logic [N-1:0]                fast_lost_i,
  input wire logic [N-1:0]                gage_on_i,
  input wire logic [N-1:0]                read_req_o,
  input wire logic [N-1:0]                power_on_o,
  input wire logic [N-1:0]                zero_o,
  input wire logic [N-1:0]                ident_o,
  input wire logic [N-1:0]                fast_ok_o,
  input wire logic                        send_units_o,
  input wire logic                        send_runout_label_o,
  input wire logic                        continuous_o,
  input wire gage_slot_pkg::fmt_t         fmt_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gage_slot_pkg::*;
  // ----
  // Helper state
  // ----
  typedef struct packed {
    logic [1:0] run_cnt; // Edges since release, saturating
    logic       lost;    // Channel 2 left fast mode
  } chk_st_t;
  chk_st_t st_ff;
  chk_st_t nxt_st;
  // Count conservatively so channel init is surely over
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.run_cnt != 2'h3) nxt_st.run_cnt = st_ff.run_cnt + 2'h1;
    if (fast_lost_i[2]) nxt_st.lost = 1'b1;
    if (srst_i) nxt_st = '0;
  end
  always_ff @(posedge sys_clk_i) begin
    st_ff <= nxt_st;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ----
  // Properties
  // ----
  sequence released_s;
    $fell(srst_i);
  endsequence
  sequence chip_up_s(logic fast);
    released_s ##0 (family_i[2 + !fast] == FAM_CHIP && fast_cable_i[2 + !fast] == fast);
  endsequence
  AST_UNITS: assert property (1'b1 |=> send_units_o == $past(slot_sw_i[SW_UNITS]))
    else $error("units select wrong");
  AST_LABEL: assert property (slot_sw_i[SW_CHID] && slot_sw_i[6:4] == FMT_CODE_RUN
    |=> send_runout_label_o) else $error("runout label missing");
  AST_CONT: assert property (1'b1 |=> continuous_o == $past(slot_sw_i[SW_CONT]))
    else $error("continuous select wrong");
  AST_FMT: assert property (slot_sw_i[6:4] == FMT_CODE_MUX |=> fmt_mode_o == FMT_LEGACY_MUX)
    else $error("format decode wrong");
  AST_BTN_ONLY: assert property (family_i[0] == FAM_BTN_ONLY && st_ff.run_cnt == 2'h3
    |-> !read_req_o[0]) else $error("request to button-only gage");
  AST_HOST: assert property (host_read_i[1] && st_ff.run_cnt == 2'h3
    && family_i[1] inside {FAM_STD, FAM_DIAL} |=> read_req_o[1]) else $error("host read lost");
  AST_LOST: assert property (st_ff.lost |-> !fast_ok_o[2])
    else $error("fast mode came back");
  AST_ZERO: assert property (chip_up_s(1'b1) |=> zero_o[2])
    else $error("fast gage not zeroed");
  AST_SLOW: assert property (chip_up_s(1'b0) |=> !zero_o[3] [*4])
    else $error("slow gage zeroed");
  // An off gage on the standard-like input is woken in the cycle after release
  AST_WAKE: assert property (released_s ##0 (family_i[0] == FAM_STD_LIKE && !gage_on_i[0])
    |=> power_on_o[0]) else $error("off gage not woken");
  AST_IDENT: assert property (released_s ##0 (family_i[1] != FAM_STD_LIKE) |=> ident_o[1])
    else $error("gage not identified");
endmodule // gage_slot_asserts
bind gage_slot_reader gage_slot_asserts #(.N(N)) u_chk (.sys_clk_i, .srst_i, .slot_sw_i,
  .family_i, .fast_cable_i, .host_read_i, .fast_lost_i, .gage_on_i, .read_req_o, .power_on_o,
  .zero_o, .ident_o, .fast_ok_o, .send_units_o, .send_runout_label_o, .continuous_o,
  .fmt_mode_o);
`default_nettype wire

/* verif/gage_slot_reader_tb_top.sv */
`default_nettype none
module gage_slot_reader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gage_slot_pkg::*;
  localparam int N = 4;
  localparam int W = 24;
  localparam logic [W-1:0] VAL = 24'h012345;
  localparam logic [W-1:0] NEG = ~VAL + 1'b1;
  localparam logic [2:0] CODES[5] = '{FMT_CODE_STD, FMT_CODE_RUN, FMT_CODE_LEFT,
    FMT_CODE_PRN, FMT_CODE_MUX};
  localparam fmt_t FMTS[5] = '{FMT_STANDARD, FMT_RUNOUT, FMT_LEFT_JUSTIFY, FMT_PRINTER,
    FMT_LEGACY_MUX};
  localparam logic [2:0] DECS[3] = '{3'h3, 3'h4, 3'h2};
  logic                 sys_clk_i, srst_i, deb_short_i, mult_invert_i, send_units_o;
  logic                 send_chan_id_o, send_runout_label_o, continuous_o;
  logic [7:0]           slot_sw_i;
  logic [1:0]           mult_shift_i;
  fam_t [N-1:0]         family_i, gage_type_o;
  fmt_t                 fmt_mode_o;
  logic [N-1:0][1:0]    dec_wiring_i;
  logic [N-1:0]         fast_cable_i, gage_btn_i, remote_sw_i, host_read_i, gage_on_i;
  logic [N-1:0]         gage_blank_i, fast_lost_i, frame_valid_i, frame_inch_i, read_req_o;
  logic [N-1:0]         power_on_o, zero_o, ident_o, fast_ok_o, meas_valid_o, meas_inch_o;
  logic [N-1:0][W-1:0]  frame_value_i, meas_value_o;
  logic [N-1:0][2:0]    frame_dec_i, meas_dec_o;
  logic [N-1:0]         req;
  int                   err_count, checks_done, cyc, n;
  bit                   got;
  // ----
  // Clock, parts and timeout
  // ----
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // One gage per input, each answering at its own pace
  for (genvar g = 0; g < N; g++) begin : g_gage
    gage_model #(.W(W), .VAL(VAL)) u_gage (.clk_i(sys_clk_i), .req_i(read_req_o[g]),
      .btn_i(gage_btn_i[g]), .wake_i(power_on_o[g]), .dly_i(8'(2 + 7 * g)),
      .frame_valid_o(frame_valid_i[g]), .frame_value_o(frame_value_i[g]), .on_o(gage_on_i[g]));
  end
  // Short open times keep debounce runs brief
  gage_slot_reader #(.N(N), .W(W), .DEB_SHORT(20), .DEB_LONG(100)) dut (.sys_clk_i, .srst_i,
    .slot_sw_i, .deb_short_i, .mult_invert_i, .mult_shift_i, .family_i, .dec_wiring_i,
    .fast_cable_i, .gage_btn_i, .remote_sw_i, .host_read_i, .gage_on_i, .gage_blank_i,
    .fast_lost_i, .frame_valid_i, .frame_value_i, .frame_dec_i, .frame_inch_i, .read_req_o,
    .power_on_o, .zero_o, .ident_o, .gage_type_o, .fast_ok_o, .meas_valid_o, .meas_value_o,
    .meas_dec_o, .meas_inch_o, .send_units_o, .send_chan_id_o, .send_runout_label_o,
    .continuous_o, .fmt_mode_o);
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    checks_done++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got_v, exp_v);
    end
  endtask
  task automatic rst(input fam_t [N-1:0] fam, input int len);
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    family_i <= fam;
    repeat (len) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
  endtask
  // Kind: 0 button, 1 host, 2 remote closure, 3 fast loss
  task automatic pulse(input int k, input int ch);
    @(posedge sys_clk_i);
    case (k)
      0: gage_btn_i[ch] <= 1'b1;
      1: host_read_i[ch] <= 1'b1;
      2: remote_sw_i[ch] <= 1'b1;
      default: fast_lost_i[ch] <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    gage_btn_i <= '0;
    host_read_i <= '0;
    remote_sw_i <= '0;
    fast_lost_i <= '0;
    #1 req = read_req_o;
  endtask
  task automatic wait_meas(input int ch);
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(posedge sys_clk_i);
      #1 got = (meas_valid_o[ch] === 1'b1);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    {srst_i, deb_short_i, mult_invert_i, slot_sw_i, mult_shift_i} = {1'b1, 1'b1, 11'h000};
    {family_i, dec_wiring_i, fast_cable_i, gage_btn_i, remote_sw_i, host_read_i} = '0;
    {gage_blank_i, fast_lost_i, frame_inch_i} = '0;
    frame_dec_i = {N{3'h3}};
    {err_count, checks_done, cyc} = '0;
    rst({FAM_STD, FAM_ANGLE, FAM_STD, FAM_STD_LIKE}, 12);
    chk(gage_on_i[0], 1);
    chk(gage_type_o[0], FAM_STD);
    chk(gage_type_o[2], FAM_STD);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_i) slot_sw_i <= {1'b0, CODES[i], 2'h0, 2'(i % 2 * 3)};
      repeat (2) @(posedge sys_clk_i);
      #1 chk(fmt_mode_o, FMTS[i]);
      chk({send_units_o, send_chan_id_o}, i % 2 * 3);
      chk(send_runout_label_o, i == 1);
    end
    @(posedge sys_clk_i) slot_sw_i <= 8'h00;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i) mult_invert_i <= (i == 1);
      mult_shift_i <= 2'(i);
      pulse(1, 1);
      chk(req, 4'h2);
      wait_meas(1);
      chk(meas_value_o[1], (i == 1) ? NEG : VAL);
      chk(meas_dec_o[1], DECS[i]);
    end
    pulse(0, 1);
    chk(req, 4'h2);
    pulse(0, 2);
    chk(req, 4'h4);
    wait_meas(2);
    chk(got, 1);
    @(posedge sys_clk_i) gage_blank_i <= 4'h2;
    pulse(1, 1);
    wait_meas(1);
    chk(got, 0);
    @(posedge sys_clk_i) gage_blank_i <= '0;
    slot_sw_i <= 8'h08;
    // Shift left over from the multiplier runs would skew later decimals
    mult_shift_i <= 2'h0;
    n = 0;
    repeat (80) begin
      @(posedge sys_clk_i);
      #1 n += read_req_o[1];
    end
    chk(n > 1, 1);
    @(posedge sys_clk_i) slot_sw_i <= 8'h04;
    dec_wiring_i <= {N{WIRE_SEL}};
    fast_cable_i <= 4'h4;
    frame_dec_i <= {N{3'h1}};
    rst({FAM_CHIP, FAM_CHIP, FAM_DIAL, FAM_BTN_ONLY}, 2);
    pulse(1, 0);
    chk(req, 4'h0);
    pulse(0, 0);
    wait_meas(0);
    chk(got, 1);
    pulse(1, 1);
    wait_meas(1);
    chk(meas_dec_o[1], DEC_THREE);
    pulse(0, 1);
    chk(req, 4'h0);
    chk(fast_ok_o[2], 1);
    pulse(0, 2);
    chk(req, 4'h4);
    wait_meas(2);
    chk(meas_inch_o[2], 1);
    // Selectable cable with position 3 off, then a fixed four-place cable
    @(posedge sys_clk_i) slot_sw_i <= 8'h00;
    pulse(1, 1);
    wait_meas(1);
    chk(meas_dec_o[1], DEC_FIVE);
    @(posedge sys_clk_i) dec_wiring_i[1] <= WIRE_D4;
    pulse(1, 1);
    wait_meas(1);
    chk(meas_dec_o[1], DEC_FOUR);
    pulse(3, 2);
    chk(fast_ok_o[2], 0);
    pulse(0, 2);
    chk(req, 4'h0);
    pulse(0, 3);
    chk(req, 4'h0);
    pulse(2, 3);
    chk(req, 4'h8);
    repeat (10) @(posedge sys_clk_i);
    pulse(2, 3);
    chk(req, 4'h0);
    repeat (25) @(posedge sys_clk_i);
    pulse(2, 3);
    chk(req, 4'h8);
    @(posedge sys_clk_i) deb_short_i <= 1'b0;
    repeat (50) @(posedge sys_clk_i);
    pulse(2, 3);
    chk(req, 4'h0);
    repeat (110) @(posedge sys_clk_i);
    pulse(2, 3);
    chk(req, 4'h8);
    conclude();
  end
endmodule // gage_slot_reader_tb_top
`default_nettype wire
